/* cmb_multiplier_block.sv */
// configurable hard multiplier: eight 9x9, four 18x18 or one 36x36
`timescale 1ns/1ns
`include "cmb_params.svh"

module cmb_multiplier_block (
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire logic                   aclr,
  input  wire cmb_pkg::cmb_mode_type  mode,
  input  wire cmb_pkg::cmb_sign_type  sign_cfg_a,
  input  wire cmb_pkg::cmb_sign_type  sign_cfg_b,
  input  wire logic                   shared_sign,
  input  wire logic                   signa,
  input  wire logic                   signb,
  input  wire logic                   input_reg_on,
  input  wire logic                   pipe_reg_on,
  input  wire logic                   shift_on,
  input  wire logic [`CMB_N18-1:0]    shift_in,
  input  wire logic [`CMB_DATA_W-1:0] data_a,
  input  wire logic [`CMB_DATA_W-1:0] data_b,
  output logic      [`CMB_RES_W-1:0]  result,
  output logic                        result_signed
);
  import cmb_pkg::*;

  // ----------------------------------------------------------------
  // sign decoding helpers
  // ----------------------------------------------------------------

  // effective sign of one operand from its convention and its control
  // an illegal code reads as unsigned so a bad setting cannot flip a product
  function automatic logic eff_sign(input cmb_sign_type cfg, input logic dyn);
    logic s;
    s = 1'b0;
    unique case (cfg)
      CMB_SIGN_UNSIGNED: s = 1'b0;
      CMB_SIGN_SIGNED:   s = 1'b1;
      CMB_SIGN_DYNAMIC:  s = dyn;
      default:           s = 1'b0;
    endcase
    return s;
  endfunction

  // whether an operand must drop to 35 bits in wide mode, given its partner
  // narrow lanes never trim; a shared control keeps both dynamic operands whole
  function automatic logic needs_limit(input cmb_sign_type self_cfg,
                                       input cmb_sign_type other_cfg,
                                       input logic         shared);
    logic lim;
    lim = 1'b0;
    unique case (self_cfg)
      CMB_SIGN_UNSIGNED: lim = (other_cfg != CMB_SIGN_UNSIGNED);
      CMB_SIGN_SIGNED:   lim = 1'b0;
      CMB_SIGN_DYNAMIC:  lim = (other_cfg == CMB_SIGN_SIGNED) ||
                               (other_cfg == CMB_SIGN_DYNAMIC && !shared);
      default:           lim = 1'b0;
    endcase
    return lim;
  endfunction

  // keep the low 35 bits and rebuild bit 35 as the sign of the shorter value
  // whatever the caller put in bit 35 is lost, so a limited operand must fit 35 bits
  function automatic logic [`CMB_N36-1:0] limit_op(input logic [`CMB_N36-1:0] op,
                                                   input logic                sgn);
    return {sgn & op[`CMB_NLIM-1], op[`CMB_NLIM-1:0]};
  endfunction

  // extend a partial product to the wide adder width
  function automatic logic [`CMB_WIDE_W-1:0] ext_prod(input logic [`CMB_UPROD_W-1:0] p,
                                                      input logic                   sgn);
    return {{(`CMB_WIDE_W-`CMB_UPROD_W){sgn & p[`CMB_UPROD_W-1]}}, p};
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                    wide;
  logic                    split;
  logic [`CMB_DATA_W-1:0]  a_reg;
  logic [`CMB_DATA_W-1:0]  b_reg;
  logic [`CMB_DATA_W-1:0]  next_a_chain;
  logic                    signa_reg;
  logic                    signb_reg;
  logic [`CMB_DATA_W-1:0]  a_sel;
  logic [`CMB_DATA_W-1:0]  b_sel;
  logic                    sa_raw;
  logic                    sb_raw;
  logic                    sa_eff;
  logic                    sb_eff;
  logic                    wide_sgn;
  logic [`CMB_N36-1:0]     wa;
  logic [`CMB_N36-1:0]     wb;
  logic [`CMB_UPROD_W-1:0] prod     [`CMB_UNITS];
  logic [`CMB_UPROD_W-1:0] prod_reg [`CMB_UNITS];
  logic [`CMB_UPROD_W-1:0] prod_sel [`CMB_UNITS];
  logic                    wide_sgn_reg;
  logic                    narrow_sgn_reg;
  logic                    wide_sgn_sel;
  logic                    narrow_sgn_sel;
  logic [`CMB_WIDE_W-1:0]  wide_sum;
  logic [`CMB_RES_W-1:0]   next_result;
  logic                    next_result_signed;

  // mode decode, static between streams
  assign wide  = (mode == CMB_MODE_36X36);
  assign split = (mode == CMB_MODE_9X9);

  // ----------------------------------------------------------------
  // input register stage with operand shift chain
  // ----------------------------------------------------------------

  // the chain moves operand A one lane up, fed from the neighbouring block
  // split mode moves nine bits per edge, the other narrow mode eighteen
  // the chain only shows at the multipliers while the input register is in use
  always_comb begin
    if (split) begin
      next_a_chain = {a_reg[`CMB_DATA_W-`CMB_N9-1:0], shift_in[`CMB_N9-1:0]};
    end else begin
      next_a_chain = {a_reg[`CMB_DATA_W-`CMB_N18-1:0], shift_in};
    end
  end

  // operand registers; the chain is cut in wide mode since lanes lose meaning
  // aclr acts at once and wins over the synchronous rstn
  always_ff @(posedge clock or posedge aclr) begin
    if (aclr) begin
      a_reg <= '0;
      b_reg <= '0;
    end else if (!rstn) begin
      a_reg <= '0;
      b_reg <= '0;
    end else begin
      if (shift_on && !wide) begin
        a_reg <= next_a_chain;
      end else begin
        a_reg <= data_a;
      end
      b_reg <= data_b;
    end
  end

  // sign controls take the same single stage as the operands, never more
  always_ff @(posedge clock or posedge aclr) begin
    if (aclr) begin
      signa_reg <= 1'b0;
      signb_reg <= 1'b0;
    end else if (!rstn) begin
      signa_reg <= 1'b0;
      signb_reg <= 1'b0;
    end else begin
      signa_reg <= signa;
      signb_reg <= signb;
    end
  end

  // bypass muxes keep operands and signs on the same cycle
  // a sign one cycle ahead of its data would mis-sign the product at each change
  assign a_sel  = input_reg_on ? a_reg : data_a;
  assign b_sel  = input_reg_on ? b_reg : data_b;
  assign sa_raw = input_reg_on ? signa_reg : signa;
  assign sb_raw = input_reg_on ? signb_reg : signb;

  // ----------------------------------------------------------------
  // sign resolution and wide operand limits
  // ----------------------------------------------------------------

  // a shared control drives both dynamic operands from sign A
  // signb is then ignored, which keeps two dynamic operands at 36 bits in wide mode
  assign sa_eff = eff_sign(sign_cfg_a, sa_raw);
  assign sb_eff = eff_sign(sign_cfg_b, shared_sign ? sa_raw : sb_raw);

  // once limited, an unsigned operand is a positive signed value, so one flag fits
  // a limited operand whose sign is clear has bit 35 low, so it stays positive
  assign wide_sgn = sa_eff | sb_eff;
  assign wa = needs_limit(sign_cfg_a, sign_cfg_b, shared_sign) ?
              limit_op(a_sel[`CMB_N36-1:0], sa_eff) : a_sel[`CMB_N36-1:0];
  assign wb = needs_limit(sign_cfg_b, sign_cfg_a, shared_sign) ?
              limit_op(b_sel[`CMB_N36-1:0], sb_eff) : b_sel[`CMB_N36-1:0];

  // ----------------------------------------------------------------
  // four multiplier units
  // ----------------------------------------------------------------
  // in wide mode unit k takes the high half of A when bit 0 of k is set
  // and the high half of B when bit 1 is set; low halves are unsigned
  // unsigned low halves keep every cross term exact within 36 bits
  for (genvar k = 0; k < `CMB_UNITS; k++) begin : g_unit
    localparam bit HI_A = (k % 2) == 1;
    localparam bit HI_B = k >= 2;

    cmb_mult_if u_if ();

    always_comb begin
      if (wide) begin
        u_if.a        = HI_A ? wa[`CMB_N36-1:`CMB_N18] : wa[`CMB_N18-1:0];
        u_if.b        = HI_B ? wb[`CMB_N36-1:`CMB_N18] : wb[`CMB_N18-1:0];
        u_if.a_signed = HI_A & wide_sgn;
        u_if.b_signed = HI_B & wide_sgn;
      end else begin
        u_if.a        = a_sel[k*`CMB_N18 +: `CMB_N18];
        u_if.b        = b_sel[k*`CMB_N18 +: `CMB_N18];
        u_if.a_signed = sa_eff;
        u_if.b_signed = sb_eff;
      end
      u_if.split = split;
    end

    cmb_mult_unit u_unit (
      .mul (u_if.unit)
    );

    assign prod[k] = u_if.product;
  end

  // ----------------------------------------------------------------
  // result register stage, pipeline of the wide multiplier
  // ----------------------------------------------------------------

  // in wide mode this stage sits between the units and the shifting adder
  // the sign flags ride along so each product meets its own sign at the adder
  always_ff @(posedge clock or posedge aclr) begin
    if (aclr) begin
      for (int i = 0; i < `CMB_UNITS; i++) begin
        prod_reg[i] <= '0;
      end
      wide_sgn_reg   <= 1'b0;
      narrow_sgn_reg <= 1'b0;
    end else if (!rstn) begin
      for (int i = 0; i < `CMB_UNITS; i++) begin
        prod_reg[i] <= '0;
      end
      wide_sgn_reg   <= 1'b0;
      narrow_sgn_reg <= 1'b0;
    end else begin
      for (int i = 0; i < `CMB_UNITS; i++) begin
        prod_reg[i] <= prod[i];
      end
      wide_sgn_reg   <= wide_sgn;
      narrow_sgn_reg <= sa_eff | sb_eff;
    end
  end

  // bypass picks the live products when the stage is not used
  // one stage at most, so the latency stays fixed by pipe_reg_on alone
  always_comb begin
    for (int i = 0; i < `CMB_UNITS; i++) begin
      prod_sel[i] = pipe_reg_on ? prod_reg[i] : prod[i];
    end
  end
  assign wide_sgn_sel   = pipe_reg_on ? wide_sgn_reg : wide_sgn;
  assign narrow_sgn_sel = pipe_reg_on ? narrow_sgn_reg : (sa_eff | sb_eff);

  // ----------------------------------------------------------------
  // shifting adder and output register
  // ----------------------------------------------------------------

  // low by low is unsigned; cross terms weigh 2^18, high by high 2^36
  // the sum wraps at 72 bits, the full product width, so no carry is lost
  assign wide_sum = ext_prod(prod_sel[0], 1'b0)
                  + (ext_prod(prod_sel[1], wide_sgn_sel) << `CMB_SHIFT1)
                  + (ext_prod(prod_sel[2], wide_sgn_sel) << `CMB_SHIFT1)
                  + (ext_prod(prod_sel[3], wide_sgn_sel) << `CMB_SHIFT2);

  // narrow lanes pack in order; the wide product fills the low 72 bits
  // the unused upper half is held at zero so wide results are unambiguous
  always_comb begin
    if (wide) begin
      next_result        = {{(`CMB_RES_W-`CMB_WIDE_W){1'b0}}, wide_sum};
      next_result_signed = wide_sgn_sel;
    end else begin
      next_result        = {prod_sel[3], prod_sel[2], prod_sel[1], prod_sel[0]};
      next_result_signed = narrow_sgn_sel;
    end
  end

  // output register is always present so the ports stay registered
  // trade-off: one cycle more latency for a clean clock-to-output path
  always_ff @(posedge clock or posedge aclr) begin
    if (aclr) begin
      result        <= '0;
      result_signed <= 1'b0;
    end else if (!rstn) begin
      result        <= '0;
      result_signed <= 1'b0;
    end else begin
      result        <= next_result;
      result_signed <= next_result_signed;
    end
  end

endmodule

/* cmb_params.svh */
// constants for the configurable multiplier block
`ifndef CMB_PARAMS_SVH
`define CMB_PARAMS_SVH

// ----------------------------------------------------------------
// operand and lane widths
// ----------------------------------------------------------------
`define CMB_N9      9
`define CMB_N18     18
`define CMB_N36     36
`define CMB_NLIM    35
`define CMB_DATA_W  72
`define CMB_RES_W   144

// ----------------------------------------------------------------
// partial products and wide adder
// ----------------------------------------------------------------
`define CMB_UNITS   4
`define CMB_UPROD_W 36
`define CMB_WIDE_W  72
`define CMB_SHIFT1  18
`define CMB_SHIFT2  36

`endif

/* cmb_pkg.sv */
// types shared by the configurable multiplier block
package cmb_pkg;

  // ----------------------------------------------------------------
  // multiplier split and operand sign conventions
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMB_MODE_9X9,
    CMB_MODE_18X18,
    CMB_MODE_36X36
  } cmb_mode_type;

  typedef enum logic [1:0] {
    CMB_SIGN_UNSIGNED,
    CMB_SIGN_SIGNED,
    CMB_SIGN_DYNAMIC
  } cmb_sign_type;

endpackage

/* cmb_mult_if.sv */
// carrier between the block and one 18 by 18 multiplier unit
`timescale 1ns/1ns
`include "cmb_params.svh"

interface cmb_mult_if;
  logic [`CMB_N18-1:0]     a;
  logic [`CMB_N18-1:0]     b;
  logic                    a_signed;
  logic                    b_signed;
  logic                    split;
  logic [`CMB_UPROD_W-1:0] product;

  modport unit (
    input  a,
    input  b,
    input  a_signed,
    input  b_signed,
    input  split,
    output product
  );

  modport host (
    output a,
    output b,
    output a_signed,
    output b_signed,
    output split,
    input  product
  );
endinterface

/* cmb_mult_unit.sv */
// one 18 by 18 multiplier that can also act as two 9 by 9 multipliers
`timescale 1ns/1ns
`include "cmb_params.svh"

module cmb_mult_unit (
  cmb_mult_if.unit mul
);
  import cmb_pkg::*;

  logic signed [2*`CMB_N18+1:0] full_prod;
  logic signed [2*`CMB_N9+1:0]  lo_prod;
  logic signed [2*`CMB_N9+1:0]  hi_prod;

  // ----------------------------------------------------------------
  // products
  // ----------------------------------------------------------------
  // one extra bit per operand lets a single signed multiply cover both conventions
  assign full_prod = $signed({mul.a_signed & mul.a[`CMB_N18-1], mul.a})
                   * $signed({mul.b_signed & mul.b[`CMB_N18-1], mul.b});
  assign lo_prod   = $signed({mul.a_signed & mul.a[`CMB_N9-1], mul.a[`CMB_N9-1:0]})
                   * $signed({mul.b_signed & mul.b[`CMB_N9-1], mul.b[`CMB_N9-1:0]});
  assign hi_prod   = $signed({mul.a_signed & mul.a[`CMB_N18-1], mul.a[`CMB_N18-1:`CMB_N9]})
                   * $signed({mul.b_signed & mul.b[`CMB_N18-1], mul.b[`CMB_N18-1:`CMB_N9]});

  // split packs two 18-bit lane products, upper lane in the upper half
  assign mul.product = mul.split ? {hi_prod[2*`CMB_N9-1:0], lo_prod[2*`CMB_N9-1:0]}
                                 : full_prod[`CMB_UPROD_W-1:0];
endmodule

/* cmb_multiplier_block_asserts.sv */
// concurrent checks on the multiplier block ports
`timescale 1ns/1ns
`include "cmb_params.svh"

module cmb_multiplier_block_asserts (
  input logic                   clock,
  input logic                   rstn,
  input logic                   aclr,
  input cmb_pkg::cmb_mode_type  mode,
  input cmb_pkg::cmb_sign_type  sign_cfg_a,
  input cmb_pkg::cmb_sign_type  sign_cfg_b,
  input logic                   shared_sign,
  input logic                   signa,
  input logic                   signb,
  input logic                   input_reg_on,
  input logic                   pipe_reg_on,
  input logic                   shift_on,
  input logic [`CMB_N18-1:0]    shift_in,
  input logic [`CMB_DATA_W-1:0] data_a,
  input logic [`CMB_DATA_W-1:0] data_b,
  input logic [`CMB_RES_W-1:0]  result,
  input logic                   result_signed
);
  import cmb_pkg::*;
  // ----------------------------------------------------------------
  // settle tracking and reference products
  // ----------------------------------------------------------------
  logic [9:0]         cfg;
  logic [9:0]         cfg_d;
  logic [2:0]         steady;
  logic               ok;
  logic               uu;
  logic               ss;
  logic [35:0]        p18;
  logic signed [17:0] p9;
  logic signed [71:0] p36;
  logic signed [71:0] p35;

  // products are only judged once every stage holds values of one setup
  assign cfg = {mode, sign_cfg_a, sign_cfg_b, shared_sign, input_reg_on, pipe_reg_on, shift_on};
  assign ok  = (steady == 3'h4) && (cfg == cfg_d);
  assign uu  = (sign_cfg_a == CMB_SIGN_UNSIGNED) && (sign_cfg_b == CMB_SIGN_UNSIGNED);
  assign ss  = (sign_cfg_a == CMB_SIGN_SIGNED) && (sign_cfg_b == CMB_SIGN_SIGNED);
  assign p18 = {18'h0, data_a[17:0]} * {18'h0, data_b[17:0]};
  assign p9  = $signed(data_a[71:63]) * $signed(data_b[71:63]);
  assign p36 = $signed(data_a[35:0]) * $signed(data_b[35:0]);
  assign p35 = $signed({1'b0, data_a[34:0]}) * $signed(data_b[35:0]);

  // counts edges with an unchanged setup, saturating past the deepest pipeline
  always_ff @(posedge clock) begin
    cfg_d <= cfg;
    if (!rstn || aclr || cfg != cfg_d) begin
      steady <= 3'h0;
    end else if (steady != 3'h4) begin
      steady <= steady + 3'h1;
    end
  end

  default clocking dcb @(posedge clock); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  clear_zero_a: assert property (
    aclr |-> result == '0 && !result_signed) else $error("result not cleared by aclr");
  reset_zero_a: assert property (
    disable iff (aclr) !rstn |=> result == '0 && !result_signed) else $error("result not cleared by reset");
  wide_upper_a: assert property (
    ok && mode == CMB_MODE_36X36 |-> result[143:72] == '0) else $error("wide mode upper half not zero");
  unsigned_flag_a: assert property (
    ok && uu |-> !result_signed) else $error("unsigned product flagged signed");
  signed_flag_a: assert property (
    ok && (sign_cfg_a == CMB_SIGN_SIGNED || sign_cfg_b == CMB_SIGN_SIGNED) |-> result_signed)
    else $error("signed product not flagged");
  direct_path_a: assert property (
    ok && mode == CMB_MODE_18X18 && uu && !input_reg_on && !pipe_reg_on |-> result[35:0] == $past(p18))
    else $error("18x18 lane wrong with one stage");
  full_pipe_a: assert property (
    ok && mode == CMB_MODE_18X18 && uu && input_reg_on && pipe_reg_on |-> result[35:0] == $past(p18, 3))
    else $error("18x18 lane wrong with three stages");
  lane9_signed_a: assert property (
    ok && mode == CMB_MODE_9X9 && ss && !input_reg_on && !pipe_reg_on |-> result[143:126] == $past(p9))
    else $error("9x9 top lane wrong");
  wide_signed_a: assert property (
    ok && mode == CMB_MODE_36X36 && ss && input_reg_on && !pipe_reg_on |-> result[71:0] == $past(p36, 2))
    else $error("36x36 signed product wrong");
  mixed_limit_a: assert property (
    ok && mode == CMB_MODE_36X36 && !input_reg_on && !pipe_reg_on && sign_cfg_a == CMB_SIGN_UNSIGNED
    && sign_cfg_b == CMB_SIGN_SIGNED |-> result[71:0] == $past(p35)) else $error("35 by 36 product wrong");
endmodule

bind cmb_multiplier_block cmb_multiplier_block_asserts u_asserts (
  .clock(clock), .rstn(rstn), .aclr(aclr), .mode(mode), .sign_cfg_a(sign_cfg_a), .sign_cfg_b(sign_cfg_b),
  .shared_sign(shared_sign), .signa(signa), .signb(signb), .input_reg_on(input_reg_on),
  .pipe_reg_on(pipe_reg_on), .shift_on(shift_on), .shift_in(shift_in), .data_a(data_a), .data_b(data_b),
  .result(result), .result_signed(result_signed));

/* cmb_fabric.sv */
// fabric model that presents operands to the multiplier block
`timescale 1ns/1ns
`include "cmb_params.svh"

module cmb_fabric (
  input  logic                   clock,
  input  logic                   load,
  input  logic [`CMB_DATA_W-1:0] a_next,
  input  logic [`CMB_DATA_W-1:0] b_next,
  output logic [`CMB_DATA_W-1:0] data_a,
  output logic [`CMB_DATA_W-1:0] data_b
);
  logic [`CMB_DATA_W-1:0] last_a;
  logic [`CMB_DATA_W-1:0] last_b;

  // between operands the lanes toggle, so a stale operand never passes for a fresh one
  assign data_a = load ? a_next : ~last_a;
  assign data_b = load ? b_next : ~last_b;

  always_ff @(posedge clock) begin
    last_a <= data_a;
    last_b <= data_b;
  end
endmodule

/* test_configurable_multiplier_block.sv */
// self-checking bench for the configurable multiplier block
`timescale 1ns/1ns
`include "cmb_params.svh"

module test_configurable_multiplier_block;
  import cmb_pkg::*;
  typedef struct {int due; logic [`CMB_RES_W:0] val;} cmb_note_type;
  logic                   clock = 1'b0;
  logic                   rstn = 1'b0;
  logic                   aclr = 1'b0;
  cmb_mode_type           mode = CMB_MODE_9X9;
  cmb_sign_type           sign_cfg_a = CMB_SIGN_UNSIGNED;
  cmb_sign_type           sign_cfg_b = CMB_SIGN_UNSIGNED;
  logic                   shared_sign = 1'b0;
  logic                   signa = 1'b0;
  logic                   signb = 1'b0;
  logic                   input_reg_on = 1'b0;
  logic                   pipe_reg_on = 1'b0;
  logic                   shift_on = 1'b0;
  logic [`CMB_N18-1:0]    shift_in = 18'h00000;
  logic                   load = 1'b1;
  logic [`CMB_DATA_W-1:0] a_next = '0;
  logic [`CMB_DATA_W-1:0] b_next = '0;
  logic [`CMB_DATA_W-1:0] data_a;
  logic [`CMB_DATA_W-1:0] data_b;
  logic [`CMB_RES_W-1:0]  result;
  logic                   result_signed;
  logic [31:0]            seed = 32'h0000004A;
  int                     cyc = 0;
  int                     n_mismatch = 0;
  int                     checks = 0;
  cmb_note_type           q[$];
  cmb_note_type           head;

  cmb_fabric fabric (.clock(clock), .load(load), .a_next(a_next), .b_next(b_next), .data_a(data_a),
    .data_b(data_b));
  cmb_multiplier_block DUT (.clock(clock), .rstn(rstn), .aclr(aclr), .mode(mode), .sign_cfg_a(sign_cfg_a),
    .sign_cfg_b(sign_cfg_b), .shared_sign(shared_sign), .signa(signa), .signb(signb),
    .input_reg_on(input_reg_on), .pipe_reg_on(pipe_reg_on), .shift_on(shift_on), .shift_in(shift_in),
    .data_a(data_a), .data_b(data_b), .result(result), .result_signed(result_signed));

  always #2 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task check(input logic [`CMB_RES_W:0] seen, input logic [`CMB_RES_W:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // reference product; narrow lanes share one sign pair, wide mode trims limited operands to 35 bits
  function automatic logic [`CMB_RES_W:0] expect_of(input int m, ca, cb, input logic sh, sga, sgb,
                                                      input logic [71:0] a, b);
    logic sa, sb, la, lb;
    logic [143:0] r;
    logic [71:0] x, y, p;
    sa = (ca == 1) || (ca == 2 && sga);
    sb = (cb == 1) || (cb == 2 && (sh ? sga : sgb));
    la = (ca == 0 && cb != 0) || (ca == 2 && (cb == 1 || (cb == 2 && !sh)));
    lb = (cb == 0 && ca != 0) || (cb == 2 && (ca == 1 || (ca == 2 && !sh)));
    r = '0;
    for (int k = 0; k < 8; k++) begin
      if (m == 0) begin
        x = {{63{sa & a[9*k+8]}}, a[9*k +: 9]};
        y = {{63{sb & b[9*k+8]}}, b[9*k +: 9]};
        p = x * y;
        r[18*k +: 18] = p[17:0];
      end else if (m == 1 && k < 4) begin
        x = {{54{sa & a[18*k+17]}}, a[18*k +: 18]};
        y = {{54{sb & b[18*k+17]}}, b[18*k +: 18]};
        p = x * y;
        r[36*k +: 36] = p[35:0];
      end
    end
    if (m == 2) begin
      x = {36'h0, la ? sa & a[34] : a[35], a[34:0]};
      y = {36'h0, lb ? sb & b[34] : b[35], b[34:0]};
      x[71:36] = {36{sa & x[35]}};
      y[71:36] = {36{sb & y[35]}};
      r[71:0] = x * y;
    end
    return {sa | sb, r};
  endfunction

  // one setup, eight back-to-back operands, then idle until the pipe drains
  // bit 2 of r feeds operand A from the shift chain; notes start once it is full
  task stream(input int m, ca, cb, r);
    logic [95:0] wa, wb;
    logic [31:0] w;
    logic [71:0] chain;
    @(negedge clock);
    w = xs();
    mode = cmb_mode_type'(m);
    sign_cfg_a = cmb_sign_type'(ca);
    sign_cfg_b = cmb_sign_type'(cb);
    shared_sign = w[0];
    input_reg_on = r[0];
    pipe_reg_on = r[1];
    shift_on = ((m == 2) && (cb == 0)) || r[2];
    for (int i = 0; i < 8; i++) begin
      if (i > 0) @(negedge clock);
      wa = {xs(), xs(), xs()};
      wb = {xs(), xs(), xs()};
      w = xs();
      signa = w[0];
      signb = w[1];
      shift_in = w[19:2];
      load = 1'b1;
      a_next = wa[71:0];
      b_next = wb[71:0];
      chain = (m == 0) ? {chain[62:0], w[10:2]} : {chain[53:0], w[19:2]};
      if (!r[2] || i >= ((m == 0) ? 7 : 3))
        q.push_back('{cyc + 1 + r[0] + r[1], expect_of(m, ca, cb, shared_sign, w[0], w[1],
          r[2] ? chain : wa[71:0], wb[71:0])});
    end
    @(negedge clock);
    load = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  // ----------------------------------------------------------------
  // scoreboard and sequence
  // ----------------------------------------------------------------
  always @(negedge clock) begin
    if (q.size() > 0 && q[0].due == cyc) begin
      head = q.pop_front();
      check({result_signed, result}, head.val);
    end
  end

  initial begin
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    for (int m = 0; m < 3; m++)
      for (int ca = 0; ca < 3; ca++)
        for (int cb = 0; cb < 3; cb++)
          for (int r = 0; r < 4; r++)
            stream(m, ca, cb, r);
    @(negedge clock);
    aclr = 1'b1;
    #1;
    check({result_signed, result}, '0);
    @(negedge clock);
    aclr = 1'b0;
    repeat (4) @(negedge clock);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    check({result_signed, result}, '0);
    rstn = 1'b1;
    stream(2, 2, 2, 3);
    stream(0, 0, 0, 5);
    stream(1, 2, 1, 5);
    check(q.size(), 0);
    finish_test;
  end

  initial begin
    #60000;
    n_mismatch++;
    finish_test;
  end
endmodule
